// ===== hw/bmu_bit_alu.sv
`timescale 1ns/1ps
`default_nettype none
// combinational bit operator shared by register and memory paths
module bmu_bit_alu
  import bmu_pkg::*;
(
  input  wire bmu_op_t               op,          // operation
  input  wire logic [BMU_IDX_W-1:0]  bit_idx,     // selected bit number
  input  wire logic [BMU_BYTE_W-1:0] byte_in,     // operand as read
  input  wire logic                  carry_in,    // current carry
  output logic [BMU_BYTE_W-1:0]      byte_out,    // modified operand
  output logic                       carry_out,   // new carry
  output logic                       zero_out,    // new zero flag
  output logic                       writes_byte, // operand must be written back
  output logic                       sets_carry,  // carry changes
  output logic                       sets_zero    // zero flag changes
);

  logic [BMU_BYTE_W-1:0] mask; // one-hot selected bit
  logic                  sel;  // value of the selected bit

  // whole byte is always passed on, so unselected bits ride through untouched
  always_comb begin
    mask        = bmu_bit_mask(bit_idx);
    sel         = |(byte_in & mask);
    byte_out    = byte_in;
    carry_out   = carry_in;
    zero_out    = 1'b0;
    writes_byte = bmu_is_rmw(op); // [RL17]
    sets_carry  = 1'b0;
    sets_zero   = 1'b0;
    case (op)
      OP_SET_BIT:         byte_out = byte_in | mask;  // [RL2]
      OP_CLEAR_BIT:       byte_out = byte_in & ~mask; // [RL3]
      OP_INVERT_BIT:      byte_out = byte_in ^ mask;  // [RL4]
      OP_TEST_BIT: begin
        zero_out  = ~sel; // [RL5]
        sets_zero = 1'b1;
      end
      OP_AND_CARRY:       begin carry_out = carry_in & sel;  sets_carry = 1'b1; end // [RL6]
      OP_AND_INV_CARRY:   begin carry_out = carry_in & ~sel; sets_carry = 1'b1; end // [RL7]
      OP_OR_CARRY:        begin carry_out = carry_in | sel;  sets_carry = 1'b1; end // [RL8]
      OP_OR_INV_CARRY:    begin carry_out = carry_in | ~sel; sets_carry = 1'b1; end // [RL9]
      OP_XOR_CARRY:       begin carry_out = carry_in ^ sel;  sets_carry = 1'b1; end // [RL10]
      OP_XOR_INV_CARRY:   begin carry_out = carry_in ^ ~sel; sets_carry = 1'b1; end // [RL11]
      OP_LOAD_CARRY:      begin carry_out = sel;  sets_carry = 1'b1; end // [RL12]
      OP_LOAD_INV_CARRY:  begin carry_out = ~sel; sets_carry = 1'b1; end // [RL13]
      OP_STORE_CARRY:     byte_out = carry_in ? (byte_in | mask) : (byte_in & ~mask);  // [RL14]
      OP_STORE_INV_CARRY: byte_out = carry_in ? (byte_in & ~mask) : (byte_in | mask);  // [RL15]
      default:            ; // unknown code leaves everything as read
    endcase
  end

endmodule
`default_nettype wire

// ===== hw/bmu_core.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: bit number from immediate or register low bits
// RL2: set forces selected bit to one
// RL3: clear forces selected bit to zero
// RL4: invert complements the selected bit
// RL5: test loads zero flag with inverted bit
// RL6: carry becomes carry and bit
// RL7: carry becomes carry and inverted bit
// RL8: carry becomes carry or bit
// RL9: carry becomes carry or inverted bit
// RL10: carry becomes carry xor bit
// RL11: carry becomes carry xor inverted bit
// RL12: carry loaded from the bit
// RL13: carry loaded from the inverted bit
// RL14: carry stored into the bit
// RL15: inverted carry stored into the bit
// RL16: inverted variants take immediate bit numbers only
// RL17: byte-modifying operations are whole-byte read-modify-write
// RL18: memory: read byte, modify, write same address
// RL19: write-only register reads back as all ones
// RL20: seven unselected bits written back unchanged
// RL21: test and carry operations never write
module bmu_core
  import bmu_pkg::*;
(
  input  wire logic                  clk,       // cpu clock
  input  wire logic                  rst,       // synchronous reset, active high
  input  wire logic                  start,     // request strobe from decoder
  input  wire bmu_req_t              req_i,     // request fields, valid with start
  output logic                       ready,     // unit idle, start is taken
  output bmu_mem_t                   mem_o,     // memory bus request
  input  wire logic [BMU_BYTE_W-1:0] mem_rdata, // memory read byte, valid with ack
  input  wire logic                  mem_ack,   // memory cycle completes
  output bmu_res_t                   res_o      // result and flag updates
);

  // every flip-flop of the unit lives in this one record
  typedef struct packed {
    bmu_state_t            st;     // sequencer state
    bmu_req_t              req;    // request captured at acceptance
    logic [BMU_IDX_W-1:0]  idx;    // resolved bit number
    logic [BMU_BYTE_W-1:0] byte_q; // operand byte as read
    bmu_mem_t              mem;    // memory bus outputs
    bmu_res_t              res;    // result outputs
  } bmu_regs_t;

  bmu_regs_t s_q; // registered state
  bmu_regs_t s_d; // next state

  logic [BMU_IDX_W-1:0]  idx_in;    // bit number of the incoming request
  logic                  idle;      // sequencer idle
  logic [BMU_BYTE_W-1:0] rd_eff;    // read byte as the unit sees it
  bmu_op_t               alu_op;    // operator inputs, muxed by state
  logic [BMU_IDX_W-1:0]  alu_idx;   // bit number fed to the operator
  logic [BMU_BYTE_W-1:0] alu_byte;  // operand fed to the operator
  logic                  alu_cy;    // carry fed to the operator
  logic [BMU_BYTE_W-1:0] alu_out;   // modified byte
  logic                  alu_cy_o;  // new carry
  logic                  alu_z_o;   // new zero flag
  logic                  alu_wb;    // byte must be written back
  logic                  alu_sc;    // carry changes
  logic                  alu_sz;    // zero flag changes

  // the decoder chooses the bit number source per request
  assign idx_in = req_i.bit_from_reg ? req_i.reg_bit_src[BMU_IDX_W-1:0] // [RL1]
                                     : req_i.imm_bit;
  assign idle   = (s_q.st == ST_IDLE);
  assign ready  = idle;

  // a write-only register cannot be read back; its bus read gives all ones, so
  // a later write sets every other bit of it to one - software must know this
  assign rd_eff = s_q.req.wo_target ? BMU_WO_READ : mem_rdata; // [RL19]

  // while idle the operator looks at the live request, afterwards at the captured request and the bus read byte
  always_comb begin
    if (idle) begin
      alu_op   = req_i.op;
      alu_idx  = idx_in;
      alu_byte = req_i.reg_val;
      alu_cy   = req_i.carry;
    end else begin
      alu_op   = s_q.req.op;
      alu_idx  = s_q.idx;
      alu_byte = rd_eff;
      alu_cy   = s_q.req.carry;
    end
  end

  // single operator instance serves both operand paths
  bmu_bit_alu u_alu (
    .op          (alu_op),
    .bit_idx     (alu_idx),
    .byte_in     (alu_byte),
    .carry_in    (alu_cy),
    .byte_out    (alu_out),
    .carry_out   (alu_cy_o),
    .zero_out    (alu_z_o),
    .writes_byte (alu_wb),
    .sets_carry  (alu_sc),
    .sets_zero   (alu_sz)
  );

  // next-state logic of the whole unit
  always_comb begin
    s_d             = s_q;
    s_d.res.done    = 1'b0; // strobes last one cycle only
    s_d.res.illegal = 1'b0;
    s_d.res.byte_we = 1'b0;
    s_d.res.carry_we = 1'b0;
    s_d.res.zero_we = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          s_d.req = req_i;
          s_d.idx = idx_in;
          if (bmu_is_inv(req_i.op) && req_i.bit_from_reg) begin
            // refused outright: no bus cycle and no flag or register change
            s_d.res.illegal = 1'b1; // [RL16]
            s_d.res.done    = 1'b1;
          end else if (req_i.is_mem) begin
            // memory operand starts with a byte read at the target address
            s_d.st       = ST_READ; // [RL18]
            s_d.mem.rd   = 1'b1;
            s_d.mem.addr = req_i.addr;
          end else begin
            // register operand completes in one cycle, whole byte returned
            s_d.byte_q       = req_i.reg_val;
            s_d.res.byte_v   = alu_out; // [RL20]
            s_d.res.byte_we  = alu_wb;  // [RL21]
            s_d.res.carry    = alu_sc ? alu_cy_o : s_q.res.carry;
            s_d.res.carry_we = alu_sc;
            s_d.res.zero     = alu_sz ? alu_z_o : s_q.res.zero;
            s_d.res.zero_we  = alu_sz;
            s_d.res.done     = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          s_d.mem.rd     = 1'b0;
          s_d.byte_q     = rd_eff;
          s_d.res.byte_v = alu_out;
          if (alu_wb) begin
            // write the modified byte back to the very same address
            s_d.st        = ST_WRITE; // [RL18]
            s_d.mem.wr    = 1'b1;
            s_d.mem.wdata = alu_out;  // [RL20]
          end else begin
            // test and carry work ends here with no write cycle
            s_d.st           = ST_IDLE; // [RL21]
            s_d.res.carry    = alu_sc ? alu_cy_o : s_q.res.carry;
            s_d.res.carry_we = alu_sc;
            s_d.res.zero     = alu_sz ? alu_z_o : s_q.res.zero;
            s_d.res.zero_we  = alu_sz;
            s_d.res.done     = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          s_d.mem.wr   = 1'b0;
          s_d.st       = ST_IDLE;
          s_d.res.done = 1'b1;
        end
      end
      default: begin
        s_d.st     = ST_IDLE; // recover from an illegal code
        s_d.mem.rd = 1'b0;
        s_d.mem.wr = 1'b0;
      end
    endcase
  end

  // state register; reset clears everything to constants
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st     <= ST_IDLE;
      s_q.req    <= '0;
      s_q.idx    <= '0;
      s_q.byte_q <= BMU_BYTE_ZERO;
      s_q.mem    <= '0;
      s_q.res    <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_o = s_q.mem;
  assign res_o = s_q.res;

  // checks on the unit's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [BMU_BYTE_W-1:0] chk_mask; // mask of the captured bit number
  logic                  chk_sel;  // captured operand bit
  assign chk_mask = bmu_bit_mask(s_q.idx);
  assign chk_sel  = |(s_q.byte_q & chk_mask);

  // register bit number source
  property p_reg_bit_src;
    start && idle && req_i.bit_from_reg |=> s_q.idx == $past(req_i.reg_bit_src[BMU_IDX_W-1:0]);
  endproperty
  a_reg_bit_src: assert property (p_reg_bit_src) else $error("bit number not from register"); // [RL1]

  // set leaves the bit high
  property p_set;
    res_o.byte_we && s_q.req.op == OP_SET_BIT |-> (res_o.byte_v & chk_mask) != 0;
  endproperty
  a_set: assert property (p_set) else $error("set left bit low"); // [RL2]

  // clear leaves the bit low
  property p_clear;
    res_o.byte_we && s_q.req.op == OP_CLEAR_BIT |-> (res_o.byte_v & chk_mask) == 0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left bit high"); // [RL3]

  // invert flips the bit
  property p_invert;
    res_o.byte_we && s_q.req.op == OP_INVERT_BIT |-> |(res_o.byte_v & chk_mask) != chk_sel;
  endproperty
  a_invert: assert property (p_invert) else $error("invert kept bit"); // [RL4]

  // zero flag tracks the inverted bit
  property p_test;
    res_o.zero_we && s_q.req.op == OP_TEST_BIT |-> res_o.zero == !chk_sel && res_o.done;
  endproperty
  a_test: assert property (p_test) else $error("zero flag wrong after test"); // [RL5]

  // and into carry
  property p_and_carry;
    res_o.carry_we && s_q.req.op == OP_AND_CARRY |-> res_o.carry == (s_q.req.carry & chk_sel);
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("and into carry wrong"); // [RL6]

  // xor inverted into carry
  property p_xor_inv;
    res_o.carry_we && s_q.req.op == OP_XOR_INV_CARRY
      |-> res_o.carry == (s_q.req.carry ^ !chk_sel);
  endproperty
  a_xor_inv: assert property (p_xor_inv) else $error("xor inverted into carry wrong"); // [RL11]

  // load into carry
  property p_load;
    res_o.carry_we && s_q.req.op == OP_LOAD_CARRY |-> res_o.carry == chk_sel;
  endproperty
  a_load: assert property (p_load) else $error("load to carry wrong"); // [RL12]

  // store carry into bit
  property p_store;
    res_o.byte_we && s_q.req.op == OP_STORE_CARRY |-> |(res_o.byte_v & chk_mask) == s_q.req.carry;
  endproperty
  a_store: assert property (p_store) else $error("store carry wrong"); // [RL14]

  // register bit number refused
  property p_illegal;
    start && idle && bmu_is_inv(req_i.op) && req_i.bit_from_reg
      |=> res_o.illegal && res_o.done && !mem_o.rd && !res_o.byte_we && !res_o.carry_we;
  endproperty
  a_illegal: assert property (p_illegal) else $error("register bit number accepted"); // [RL16]

  // write-back follows the read
  property p_rmw_order;
    s_q.st == ST_READ && mem_ack && bmu_is_rmw(s_q.req.op)
      |=> mem_o.wr && !mem_o.rd && mem_o.addr == $past(mem_o.addr);
  endproperty
  a_rmw_order: assert property (p_rmw_order) else $error("write-back not to read address"); // [RL18]

  // write-only target reads as ones
  property p_wo_read;
    s_q.st == ST_READ && mem_ack && s_q.req.wo_target |=> s_q.byte_q == BMU_WO_READ;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not all ones"); // [RL19]

  // memory: other bits kept
  property p_keep_others;
    $rose(mem_o.wr) |-> ((mem_o.wdata ^ s_q.byte_q) & ~chk_mask) == 0;
  endproperty
  a_keep_others: assert property (p_keep_others) else $error("unselected bit changed"); // [RL20]

  // no write for non-rmw ops
  property p_no_write;
    s_q.st == ST_READ && mem_ack && !bmu_is_rmw(s_q.req.op) |=> !mem_o.wr [*2];
  endproperty
  a_no_write: assert property (p_no_write) else $error("write issued for read-only op"); // [RL21]

  property p_and_inv;
    res_o.carry_we && s_q.req.op == OP_AND_INV_CARRY
      |-> res_o.carry == (s_q.req.carry & !chk_sel);
  endproperty
  a_and_inv: assert property (p_and_inv) else $error("and inverted wrong"); // [RL7]

  property p_or_carry;
    res_o.carry_we && s_q.req.op == OP_OR_CARRY
      |-> res_o.carry == (s_q.req.carry | chk_sel);
  endproperty
  a_or_carry: assert property (p_or_carry) else $error("or into carry wrong"); // [RL8]

  property p_or_inv;
    res_o.carry_we && s_q.req.op == OP_OR_INV_CARRY
      |-> res_o.carry == (s_q.req.carry | !chk_sel);
  endproperty
  a_or_inv: assert property (p_or_inv) else $error("or inverted wrong"); // [RL9]

  property p_xor_carry;
    res_o.carry_we && s_q.req.op == OP_XOR_CARRY
      |-> res_o.carry == (s_q.req.carry ^ chk_sel);
  endproperty
  a_xor_carry: assert property (p_xor_carry) else $error("xor into carry wrong"); // [RL10]

  property p_load_inv;
    res_o.carry_we && s_q.req.op == OP_LOAD_INV_CARRY
      |-> res_o.carry == !chk_sel;
  endproperty
  a_load_inv: assert property (p_load_inv) else $error("load inverted wrong"); // [RL13]

  property p_store_inv;
    res_o.byte_we && s_q.req.op == OP_STORE_INV_CARRY
      |-> |(res_o.byte_v & chk_mask) != s_q.req.carry;
  endproperty
  a_store_inv: assert property (p_store_inv) else $error("store inverted wrong"); // [RL15]

  property p_read_first;
    $rose(mem_o.wr)
      |-> $past(mem_o.rd) && mem_o.addr == $past(mem_o.addr);
  endproperty
  a_read_first: assert property (p_read_first) else $error("write without read"); // [RL17]

  property p_keep_reg;
    res_o.byte_we
      |-> ((res_o.byte_v ^ s_q.byte_q) & ~chk_mask) == 0;
  endproperty
  a_keep_reg: assert property (p_keep_reg) else $error("register bit changed"); // [RL20]

  c_mem_rmw: cover property (mem_o.wr && mem_ack ##1 res_o.done);
  c_reg_test: cover property (res_o.zero_we && s_q.req.op == OP_TEST_BIT);
  c_illegal: cover property (res_o.illegal);
  c_wo_rmw: cover property (s_q.req.wo_target && $rose(mem_o.wr));

endmodule
`default_nettype wire

// ===== hw/bmu_pkg.sv
// shared types and constants of the bit manipulation unit
package bmu_pkg;

  localparam int unsigned BMU_BYTE_W = 8;           // operand byte width
  localparam int unsigned BMU_IDX_W  = 3;           // bit number field width
  localparam int unsigned BMU_ADDR_W = 16;          // memory bus address width

  localparam logic [BMU_BYTE_W-1:0] BMU_BYTE_ZERO = 8'h00; // reset value of bytes
  localparam logic [BMU_BYTE_W-1:0] BMU_BIT0_ONE  = 8'h01; // mask seed for bit 0
  localparam logic [BMU_BYTE_W-1:0] BMU_WO_READ   = 8'hff; // a write-only register reads so
  localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_ZERO = 16'h0000; // reset value of address

  // operation codes handed over by the instruction decoder
  typedef enum logic [3:0] {
    OP_SET_BIT          = 4'h0, // set_bit_op
    OP_CLEAR_BIT        = 4'h1, // clear_bit_op
    OP_INVERT_BIT       = 4'h2, // invert_bit_op
    OP_TEST_BIT         = 4'h3, // test_bit_op
    OP_AND_CARRY        = 4'h4, // and_bit_into_carry
    OP_AND_INV_CARRY    = 4'h5, // and_inverted_bit_into_carry
    OP_OR_CARRY         = 4'h6, // or_bit_into_carry
    OP_OR_INV_CARRY     = 4'h7, // or_inverted_bit_into_carry
    OP_XOR_CARRY        = 4'h8, // xor_bit_into_carry
    OP_XOR_INV_CARRY    = 4'h9, // xor_inverted_bit_into_carry
    OP_LOAD_CARRY       = 4'ha, // load_bit_to_carry
    OP_LOAD_INV_CARRY   = 4'hb, // load_inverted_bit_to_carry
    OP_STORE_CARRY      = 4'hc, // store_carry_to_bit
    OP_STORE_INV_CARRY  = 4'hd  // store_inverted_carry_to_bit
  } bmu_op_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00, // waiting for a request
    ST_READ  = 2'b01, // memory byte read outstanding
    ST_WRITE = 2'b10  // memory byte write outstanding
  } bmu_state_t;

  // one request from the decoder
  typedef struct packed {
    bmu_op_t                 op;          // operation
    logic                    bit_from_reg; // bit number comes from a register
    logic [BMU_IDX_W-1:0]    imm_bit;     // immediate bit number
    logic [BMU_BYTE_W-1:0]   reg_bit_src; // register holding the bit number
    logic                    is_mem;      // operand lives in memory
    logic                    wo_target;   // memory target is a write-only register
    logic [BMU_ADDR_W-1:0]   addr;        // memory operand address
    logic [BMU_BYTE_W-1:0]   reg_val;     // register operand value
    logic                    carry;       // current carry flag
  } bmu_req_t;

  // memory bus request side
  typedef struct packed {
    logic                  rd;    // read request, held until ack
    logic                  wr;    // write request, held until ack
    logic [BMU_ADDR_W-1:0] addr;  // byte address
    logic [BMU_BYTE_W-1:0] wdata; // write byte
  } bmu_mem_t;

  // result towards register file and condition codes
  typedef struct packed {
    logic                  done;    // one-cycle completion pulse
    logic                  illegal; // request refused
    logic [BMU_BYTE_W-1:0] byte_v;  // result byte
    logic                  byte_we; // write byte back to general register
    logic                  carry;   // new carry
    logic                  carry_we; // carry update strobe
    logic                  zero;    // new zero flag
    logic                  zero_we; // zero update strobe
  } bmu_res_t;

  // one-hot mask of the selected bit
  function automatic logic [BMU_BYTE_W-1:0] bmu_bit_mask(input logic [BMU_IDX_W-1:0] idx);
    return BMU_BIT0_ONE << idx;
  endfunction

  // operations that rewrite the operand byte
  function automatic logic bmu_is_rmw(input bmu_op_t op);
    return (op == OP_SET_BIT) || (op == OP_CLEAR_BIT) || (op == OP_INVERT_BIT) ||
           (op == OP_STORE_CARRY) || (op == OP_STORE_INV_CARRY);
  endfunction

  // inverted variants, which only take an immediate bit number
  function automatic logic bmu_is_inv(input bmu_op_t op);
    return (op == OP_AND_INV_CARRY) || (op == OP_OR_INV_CARRY) ||
           (op == OP_XOR_INV_CARRY) || (op == OP_LOAD_INV_CARRY) ||
           (op == OP_STORE_INV_CARRY);
  endfunction

endpackage

// ===== verif/bmu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: byte memory that answers the unit's bus after a set wait
module bmu_mem_model
  import bmu_pkg::*;
(
  input  wire logic             clk,   // cpu clock
  input  wire logic             rst,   // synchronous reset, active high
  input  wire bmu_mem_t         mem_i, // bus request from the unit
  input  wire logic [1:0]       lat,   // wait cycles before each ack
  output logic [BMU_BYTE_W-1:0] rdata, // read byte, valid with ack only
  output logic                  ack,   // one-cycle completion pulse
  output var int                wcnt   // write cycles completed
);
  logic [BMU_BYTE_W-1:0] mem [256]; // backing store, low address byte decodes
  logic [1:0]            cnt;       // wait cycles served for this request

  // answer a held request after lat cycles; outside ack the read byte keeps
  // toggling so that a late sample never matches by luck
  always @(posedge clk) begin
    ack   <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt   <= 2'h0;
      wcnt  <= 0;
      rdata <= 8'h5a;
    end else if ((mem_i.rd || mem_i.wr) && !ack) begin
      if (cnt == lat) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        if (mem_i.rd) begin
          rdata <= mem[mem_i.addr[7:0]];
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
    // a write lands on the edge where the unit sees ack
    if (ack && mem_i.wr) begin
      mem[mem_i.addr[7:0]] <= mem_i.wdata;
      wcnt                 <= wcnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_bit_manipulation_unit.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the bit manipulation unit
module test_bit_manipulation_unit;
  import bmu_pkg::*;
  logic       clk, rst, start, ready, mem_ack; // clock, reset, handshake
  bmu_req_t   req;                             // request fields
  bmu_mem_t   mem;                             // bus request from the unit
  bmu_res_t   res;                             // results and strobes
  logic [7:0] rdata;                           // bus read byte
  logic [1:0] lat;                             // memory wait cycles
  int         wcnt, n_fail, compares;          // counters
  logic [7:0] e_byte;                          // expected byte
  logic       e_c, e_z, e_bw, e_cw, e_zw;      // expected flags and strobes
  logic [7:0] vals [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c}; // operand patterns

  bmu_core uut (.clk(clk), .rst(rst), .start(start), .req_i(req), .ready(ready),
                .mem_o(mem), .mem_rdata(rdata), .mem_ack(mem_ack), .res_o(res));
  bmu_mem_model mdl (.clk(clk), .rst(rst), .mem_i(mem), .lat(lat), .rdata(rdata),
                     .ack(mem_ack), .wcnt(wcnt));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // expected outcome worked out from the operation's definition
  function void expect_op(logic [3:0] op, logic [7:0] b, logic [2:0] n, logic c);
    logic v;
    v      = b[n];
    e_byte = b;
    e_c    = c;
    e_z    = ~v;
    e_cw   = (op >= 4'h4) && (op <= 4'hb);
    e_zw   = (op == 4'h3);
    e_bw   = (op <= 4'h2) || (op >= 4'hc);
    case (op)
      4'h0: e_byte[n] = 1'b1;
      4'h1: e_byte[n] = 1'b0;
      4'h2: e_byte[n] = ~v;
      4'h4: e_c = c & v;
      4'h5: e_c = c & ~v;
      4'h6: e_c = c | v;
      4'h7: e_c = c | ~v;
      4'h8: e_c = c ^ v;
      4'h9: e_c = c ^ ~v;
      4'ha: e_c = v;
      4'hb: e_c = ~v;
      4'hc: e_byte[n] = c;
      4'hd: e_byte[n] = ~c;
      default: e_byte = b;
    endcase
  endfunction

  // the one comparison used for every result
  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one request, waited for under a bound, then judged in full
  task automatic run(bmu_op_t op, logic fr, logic [2:0] n, logic mm, logic wo,
                     logic [7:0] val, logic c);
    int w0;
    int i;
    @(posedge clk) #1; // lets the last start fall for a cycle
    w0                = wcnt;
    mdl.mem[8'(op)]   = val;
    req.op            = op;
    req.bit_from_reg  = fr;
    req.imm_bit       = fr ? ~n : n;            // wrong source gives wrong bit
    req.reg_bit_src   = 8'ha8 | 8'(n);          // upper bits must be ignored
    req.is_mem        = mm;
    req.wo_target     = wo;
    req.addr          = 16'h1200 + 16'(op);
    req.reg_val       = mm ? ~val : val;        // memory path must not use it
    req.carry         = c;
    expect_op(op, wo ? 8'hff : val, n, c);
    chk({7'h00, ready}, 8'h01, "ready before start");
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    for (i = 0; i < 40 && res.done !== 1'b1; i++) @(posedge clk) #1;
    chk({7'h00, res.done}, 8'h01, "done");
    chk({7'h00, res.illegal}, 8'h00, "illegal");
    chk({7'h00, res.byte_we}, {7'h00, e_bw & ~mm}, "byte strobe");
    if (e_bw && !mm) chk(res.byte_v, e_byte, "register byte");
    chk({7'h00, res.carry_we}, {7'h00, e_cw}, "carry strobe");
    if (e_cw) chk({7'h00, res.carry}, {7'h00, e_c}, "carry");
    chk({7'h00, res.zero_we}, {7'h00, e_zw}, "zero strobe");
    if (e_zw) chk({7'h00, res.zero}, {7'h00, e_z}, "zero");
    if (mm) begin
      chk(8'(wcnt - w0), e_bw ? 8'h01 : 8'h00, "write cycles");
      chk(mdl.mem[8'(op)], e_bw ? e_byte : val, "memory byte");
    end
  endtask

  // every operation on a register, both bit sources where legal
  task automatic t_reg_all();
    for (int op = 0; op < 14; op++)
      for (int fr = 0; fr < 2; fr++)
        for (int v = 0; v < 4; v++)
          for (int c = 0; c < 2; c++)
            if (!(fr == 1 && op[0] && op >= 5))
              run(bmu_op_t'(op), fr[0], 3'(v * 3 + op), 1'b0, 1'b0, vals[v], c[0]);
    $display("test reg_all finished");
  endtask

  // every operation on memory, with changing bus latency
  task automatic t_mem_all();
    for (int op = 0; op < 14; op++)
      for (int v = 2; v < 4; v++)
        for (int c = 0; c < 2; c++) begin
          lat = 2'(op + c);
          run(bmu_op_t'(op), 1'b0, 3'(op + v), 1'b1, 1'b0, vals[v], c[0]);
        end
    lat = 2'h0;
    $display("test mem_all finished");
  endtask

  // a write-only target reads as all ones, so other bits come back set
  task automatic t_wo_read();
    run(OP_CLEAR_BIT, 1'b0, 3'h0, 1'b1, 1'b1, 8'h3f, 1'b0);
    run(OP_SET_BIT, 1'b0, 3'h7, 1'b1, 1'b1, 8'h00, 1'b1);
    $display("test wo_read finished");
  endtask

  // inverted variants with a register bit number are refused, no bus cycle
  task automatic t_refuse();
    @(posedge clk) #1;
    for (int op = 5; op < 14; op += 2) begin
      req.op           = bmu_op_t'(op);
      req.bit_from_reg = 1'b1;
      req.is_mem       = 1'b1;
      start            = 1'b1;
      @(posedge clk) #1;
      start = 1'b0;
      chk({7'h00, res.done, res.illegal}, 8'h03, "refusal pulse");
      chk({5'h00, res.byte_we, res.carry_we, res.zero_we}, 8'h00, "refusal strobes");
      chk({6'h00, mem.rd, mem.wr}, 8'h00, "refused bus idle");
      repeat (3) @(posedge clk) #1;
    end
    $display("test refuse finished");
  endtask

  // register requests on consecutive edges
  task automatic t_b2b();
    @(posedge clk) #1;
    req         = '0;
    req.op      = OP_SET_BIT;
    req.imm_bit = 3'h6;
    start       = 1'b1;
    @(posedge clk) #1;
    chk(res.byte_v, 8'h40, "first back-to-back");
    req.op      = OP_INVERT_BIT;
    req.reg_val = 8'hff;
    @(posedge clk) #1;
    start = 1'b0;
    chk({7'h00, res.done}, 8'h01, "second done");
    chk(res.byte_v, 8'hbf, "second back-to-back");
    $display("test b2b finished");
  endtask

  // counts and verdict; the only place the run ends
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst      = 1'b1;
    start    = 1'b0;
    req      = '0;
    lat      = 2'h0;
    n_fail   = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk) #1;
    t_reg_all();
    t_b2b();
    t_refuse();
    t_mem_all();
    t_wo_read();
    finish_test();
  end

  // watchdog: the whole run needs about 800 cycles
  initial begin
    #100us;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
